// ==== core/rps_map.vh ====
// register offsets, reset values and codes for the ramp profile selector
`ifndef RPS_MAP_VH
`define RPS_MAP_VH

`define RPS_AW 8
`define RPS_DW 32
`define RPS_TW 16
`define RPS_NSET 21

// setting index sits in address bits 6:2; the top address bit must be clear
`define RPS_IX_MSB 6
`define RPS_IX_LSB 2

// word index of each setting; byte address is four times the index
`define RPS_IX_PRI_ACC 5'h00
`define RPS_IX_PRI_DEC 5'h01
`define RPS_IX_PRI_SCA 5'h02
`define RPS_IX_PRI_SCD 5'h03
`define RPS_IX_FRK_RMP 5'h04
`define RPS_IX_FRK_DEC 5'h05
`define RPS_IX_FRK_SCA 5'h06
`define RPS_IX_FRK_SCD 5'h07
`define RPS_IX_THR_RMP 5'h08
`define RPS_IX_THR_DEC 5'h09
`define RPS_IX_THR_SCA 5'h0a
`define RPS_IX_THR_SCD 5'h0b
`define RPS_IX_SPF_ACC 5'h0c
`define RPS_IX_SPF_DEC 5'h0d
`define RPS_IX_SPF_SCA 5'h0e
`define RPS_IX_SPF_SCD 5'h0f
`define RPS_IX_FAIL_DEC 5'h10
`define RPS_IX_FAIL_SCD 5'h11
`define RPS_IX_MOTOR2 5'h12
`define RPS_IX_COMM_STOP 5'h13
`define RPS_IX_TERM_MAP 5'h14
`define RPS_IX_STATUS 5'h15

// times are held in units of 0.1 s; the code below stands for "9999"
`define RPS_SENTINEL 16'hffff
`define RPS_RST_5S 16'h0032
`define RPS_RST_15S 16'h0096
`define RPS_RST_SC 16'h0001
`define RPS_RST_ZERO 16'h0000

// terminal function codes; map word holds fork code [7:0], feed [15:8]
`define RPS_FN_FORK 8'h6c
`define RPS_FN_FEED 8'h6d
`define RPS_MAP_FORK_LSB 0
`define RPS_MAP_FEED_LSB 8
`define RPS_FN_W 8

// status word bit positions
`define RPS_ST_FORK 0
`define RPS_ST_SPEED 1
`define RPS_ST_THIRD 2
`define RPS_ST_ALT 3
`define RPS_ST_FAIL 4

`endif

// ==== core/rps_selector.v ====
// ramp profile selector: resolves ramp and s-curve times for the ramp gen
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/10ps
// Operation
// - fork control uses the fork ramp time for acceleration
// - fork decel uses fork decel time, or fork ramp time when sentinel
// - fork control uses its own s-curve accel and decel times
// - under fork control communication error stop acts as selection zero
// - feed select off gives position feed, on gives speed feed
// - feed select unmapped to a terminal forces position feed
// - full-closed control accelerates with the primary accel time
// - full-closed control decelerates with the primary decel time
// - full-closed control uses primary s-curve accel and decel times
// - alt pattern on uses third ramp time; sentinel disables third set
// - third decel sentinel means third ramp time also decelerates
// - alt pattern on uses third s-curve accel and decel times
// - speed feed uses speed-feed accel; sentinel disables speed-feed set
// - speed-feed decel sentinel means speed-feed accel also decelerates
// - speed feed uses speed-feed s-curve accel and decel times
// - failure stop uses failure decel, else the active normal decel
// - failure stop uses failure s-curve decel, else active normal one
// - fork times are interpreted like the primary times
// - fork needs fork select on and second motor not sentinel
// - alt pattern change while running waits until the drive stops
`include "rps_map.vh"

module rps_selector (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [`RPS_AW-1:0] addr_i,
  input wire [`RPS_DW-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [`RPS_DW-1:0] rdata_o,
  input wire fork_select_in_i,
  input wire feed_mode_select_in_i,
  input wire alt_pattern_select_in_i,
  input wire drive_running_i,
  input wire seg_start_i,
  input wire sys_fail_i,
  output reg [`RPS_TW-1:0] accel_time_o,
  output reg [`RPS_TW-1:0] decel_time_o,
  output reg [`RPS_TW-1:0] scurve_accel_o,
  output reg [`RPS_TW-1:0] scurve_decel_o,
  output reg fork_mode_o,
  output reg speed_feed_o,
  output reg [`RPS_TW-1:0] comm_stop_eff_o
);

  reg [`RPS_TW-1:0] setting [0:`RPS_NSET-1];
  reg [2:0] sync_a;
  reg [2:0] sync_b;
  reg alt_eff;
  reg fail_q;
  reg fork_q;
  reg speed_q;
  reg third_q;

  wire [4:0] word_ix = addr_i[`RPS_IX_MSB:`RPS_IX_LSB];
  wire addr_ok = (addr_i[`RPS_IX_LSB-1:0] == 2'h0) &&
    (addr_i[`RPS_AW-1] == 1'b0);
  wire [2:0] pins = {alt_pattern_select_in_i, feed_mode_select_in_i,
                     fork_select_in_i};

  // reset value per setting index
  function [`RPS_TW-1:0] rst_val;
    input [4:0] ix;
    begin
      case (ix)
        `RPS_IX_PRI_ACC, `RPS_IX_PRI_DEC, `RPS_IX_FRK_RMP,
        `RPS_IX_THR_RMP: rst_val = `RPS_RST_5S;
        `RPS_IX_PRI_SCA, `RPS_IX_PRI_SCD, `RPS_IX_FRK_SCA, `RPS_IX_FRK_SCD,
        `RPS_IX_THR_SCA, `RPS_IX_THR_SCD, `RPS_IX_SPF_SCA,
        `RPS_IX_SPF_SCD: rst_val = `RPS_RST_SC;
        `RPS_IX_COMM_STOP, `RPS_IX_TERM_MAP: rst_val = `RPS_RST_ZERO;
        default: rst_val = `RPS_SENTINEL;
      endcase
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `RPS_NSET; gi = gi + 1) begin : g_set
      localparam [4:0] set_ix = gi;
      always @(posedge mclk_i) begin
        if (sys_rst_i)
          setting[gi] <= rst_val(set_ix);
        else if (wr_i && addr_ok && word_ix == set_ix)
          setting[gi] <= wdata_i[`RPS_TW-1:0];
      end
    end
  endgenerate

  // pins come from another domain: two flops before any use
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
    end
  end

  wire fork_sel = sync_b[0];
  wire feed_sel = sync_b[1];
  wire alt_sel = sync_b[2];

  // alt pattern only follows its pin at standstill
  always @(posedge mclk_i) begin
    if (sys_rst_i)
      alt_eff <= 1'b0;
    else if (!drive_running_i)
      alt_eff <= alt_sel;
  end

  wire [`RPS_TW-1:0] map_w = setting[`RPS_IX_TERM_MAP];
  wire fork_mapped =
    map_w[`RPS_MAP_FORK_LSB +: `RPS_FN_W] == `RPS_FN_FORK;
  wire feed_mapped =
    map_w[`RPS_MAP_FEED_LSB +: `RPS_FN_W] == `RPS_FN_FEED;
  wire fork_act = fork_sel && fork_mapped &&
    setting[`RPS_IX_MOTOR2] != `RPS_SENTINEL;
  wire speed_act = !fork_act && feed_mapped && feed_sel;
  wire spf_en = speed_act &&
    setting[`RPS_IX_SPF_ACC] != `RPS_SENTINEL;
  wire third_en = !fork_act && alt_eff &&
    setting[`RPS_IX_THR_RMP] != `RPS_SENTINEL;

  reg [`RPS_TW-1:0] n_acc;
  reg [`RPS_TW-1:0] n_dec;
  reg [`RPS_TW-1:0] n_sca;
  reg [`RPS_TW-1:0] n_scd;

  // speed-feed set outranks the alt pattern, both outranked by fork
  always @* begin
    if (fork_act) begin
      n_acc = setting[`RPS_IX_FRK_RMP];
      n_dec = (setting[`RPS_IX_FRK_DEC] == `RPS_SENTINEL) ?
        setting[`RPS_IX_FRK_RMP] : setting[`RPS_IX_FRK_DEC];
      n_sca = setting[`RPS_IX_FRK_SCA];
      n_scd = setting[`RPS_IX_FRK_SCD];
    end else if (spf_en) begin
      n_acc = setting[`RPS_IX_SPF_ACC];
      n_dec = (setting[`RPS_IX_SPF_DEC] == `RPS_SENTINEL) ?
        setting[`RPS_IX_SPF_ACC] : setting[`RPS_IX_SPF_DEC];
      n_sca = setting[`RPS_IX_SPF_SCA];
      n_scd = setting[`RPS_IX_SPF_SCD];
    end else if (third_en) begin
      n_acc = setting[`RPS_IX_THR_RMP];
      n_dec = (setting[`RPS_IX_THR_DEC] == `RPS_SENTINEL) ?
        setting[`RPS_IX_THR_RMP] : setting[`RPS_IX_THR_DEC];
      n_sca = setting[`RPS_IX_THR_SCA];
      n_scd = setting[`RPS_IX_THR_SCD];
    end else begin
      n_acc = setting[`RPS_IX_PRI_ACC];
      n_dec = setting[`RPS_IX_PRI_DEC];
      n_sca = setting[`RPS_IX_PRI_SCA];
      n_scd = setting[`RPS_IX_PRI_SCD];
    end
  end

  wire [`RPS_TW-1:0] next_fail_dec =
    (setting[`RPS_IX_FAIL_DEC] == `RPS_SENTINEL) ?
    n_dec : setting[`RPS_IX_FAIL_DEC];
  wire [`RPS_TW-1:0] next_fail_scd =
    (setting[`RPS_IX_FAIL_SCD] == `RPS_SENTINEL) ?
    n_scd : setting[`RPS_IX_FAIL_SCD];
  wire fail_rise = sys_fail_i && !fail_q;

  // latched per segment so a rewrite cannot bend a ramp in progress
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fail_q <= 1'b0;
      accel_time_o <= `RPS_RST_5S;
      decel_time_o <= `RPS_RST_5S;
      scurve_accel_o <= `RPS_RST_SC;
      scurve_decel_o <= `RPS_RST_SC;
      fork_mode_o <= 1'b0;
      speed_feed_o <= 1'b0;
    end else begin
      fail_q <= sys_fail_i;
      if (seg_start_i) begin
        accel_time_o <= n_acc;
        decel_time_o <= sys_fail_i ? next_fail_dec : n_dec;
        scurve_accel_o <= n_sca;
        scurve_decel_o <= sys_fail_i ? next_fail_scd : n_scd;
        fork_mode_o <= fork_act;
        speed_feed_o <= speed_act;
      end else if (fail_rise) begin
        // a failure swaps the stop times at once, ramp or not
        decel_time_o <= next_fail_dec;
        scurve_decel_o <= next_fail_scd;
      end
    end
  end

  always @(posedge mclk_i) begin
    if (sys_rst_i)
      comm_stop_eff_o <= `RPS_RST_ZERO;
    else
      comm_stop_eff_o <= fork_act ? `RPS_RST_ZERO :
        setting[`RPS_IX_COMM_STOP];
  end

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fork_q <= 1'b0;
      speed_q <= 1'b0;
      third_q <= 1'b0;
    end else begin
      fork_q <= fork_act;
      speed_q <= speed_act;
      third_q <= third_en;
    end
  end

  wire [`RPS_DW-1:0] status_w = ({{(`RPS_DW-1){1'b0}}, fork_q}
    << `RPS_ST_FORK) | ({{(`RPS_DW-1){1'b0}}, speed_q} << `RPS_ST_SPEED)
    | ({{(`RPS_DW-1){1'b0}}, third_q} << `RPS_ST_THIRD)
    | ({{(`RPS_DW-1){1'b0}}, alt_eff} << `RPS_ST_ALT)
    | ({{(`RPS_DW-1){1'b0}}, fail_q} << `RPS_ST_FAIL);

  // read data valid only in the cycle after the strobe
  always @(posedge mclk_i) begin
    if (sys_rst_i)
      rdata_o <= {`RPS_DW{1'b0}};
    else if (rd_i && addr_ok && {27'h0, word_ix} < `RPS_NSET)
      rdata_o <= {{(`RPS_DW-`RPS_TW){1'b0}}, setting[word_ix]};
    else if (rd_i && addr_ok && word_ix == `RPS_IX_STATUS)
      rdata_o <= status_w;
    else
      rdata_o <= {`RPS_DW{1'b0}};
  end

endmodule

// ==== tb/rps_selector_chk.sv ====
// port assertions for the ramp profile selector
`timescale 1ns/10ps
module rps_chk (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire fork_select_in_i,
  input wire seg_start_i,
  input wire sys_fail_i,
  input wire [15:0] accel_time_o,
  input wire [15:0] decel_time_o,
  input wire [15:0] scurve_accel_o,
  input wire [15:0] scurve_decel_o,
  input wire fork_mode_o,
  input wire speed_feed_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  reg fail_q;
  // a failure rise re-latches the decel side as well
  wire kick = seg_start_i | (sys_fail_i & ~fail_q);
  always @(posedge mclk_i) fail_q <= sys_fail_i;
  a_rst_vals:
    assert property ($past(sys_rst_i) |-> accel_time_o == 16'h0032 &&
      scurve_accel_o == 16'h0001) else $error("bad reset ramp values");
  a_acc_hold:
    assert property (!$past(seg_start_i) |-> $stable(accel_time_o))
      else $error("accel moved without segment start");
  a_sca_hold:
    assert property (!$past(seg_start_i) |-> $stable(scurve_accel_o))
      else $error("s-curve accel moved without segment start");
  a_dec_hold:
    assert property (!$past(kick) |-> $stable(decel_time_o))
      else $error("decel moved without start or failure");
  a_scd_hold:
    assert property (!$past(kick) |-> $stable(scurve_decel_o))
      else $error("s-curve decel moved without start or failure");
  a_mode_hold:
    assert property (!$past(seg_start_i) |->
      $stable({fork_mode_o, speed_feed_o})) else $error("mode moved");
  a_fork_pin:
    assert property ($past(seg_start_i) && !$past(fork_select_in_i, 3) &&
      !$past(fork_select_in_i, 4) |-> !fork_mode_o)
      else $error("fork mode without fork select");
  a_rd_idle:
    assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside read cycle");
endmodule
bind rps_selector rps_chk chk_u (.mclk_i, .sys_rst_i, .rd_i, .rdata_o,
  .fork_select_in_i, .seg_start_i, .sys_fail_i, .accel_time_o,
  .decel_time_o, .scurve_accel_o, .scurve_decel_o, .fork_mode_o,
  .speed_feed_o);

// ==== tb/rps_host.sv ====
// host controller model: setting bus master and segment starts
`timescale 1ns/10ps
module rps_host (
  input wire mclk_i,
  input wire [31:0] rdata_i,
  output logic [7:0] addr_o = 8'h0,
  output logic [31:0] wdata_o = 32'h0,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic seg_o = 1'b0
);
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
  task seg();
    @(posedge mclk_i);
    seg_o <= 1'b1;
    @(posedge mclk_i);
    seg_o <= 1'b0;
    #1;
  endtask
endmodule

// ==== tb/rps_selector_test.sv ====
// self-checking bench for the ramp profile selector
`timescale 1ns/10ps
module rps_selector_test;
  logic mclk_i = 0, sys_rst_i = 1, fsel = 0, msel = 0, asel = 0;
  logic run = 0, fail = 0, wr, rd, seg, fmode, sfeed;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv, seed = 32'ha8db;
  logic [15:0] acc, dec, sca, scd, cst, t [0:15];
  int num_errors = 0, n_checks = 0;
  rps_selector dut_u (.mclk_i, .sys_rst_i, .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .fork_select_in_i(fsel),
    .feed_mode_select_in_i(msel), .alt_pattern_select_in_i(asel),
    .drive_running_i(run), .seg_start_i(seg), .sys_fail_i(fail),
    .accel_time_o(acc), .decel_time_o(dec), .scurve_accel_o(sca),
    .scurve_decel_o(scd), .fork_mode_o(fmode), .speed_feed_o(sfeed),
    .comm_stop_eff_o(cst));
  rps_host host_u (.mclk_i, .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .seg_o(seg));
  initial forever #5 mclk_i = ~mclk_i;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task ramp(input logic [15:0] a, d, sa, sd);
    chk("accel", a, acc);
    chk("decel", d, dec);
    chk("scurve_acc", sa, sca);
    chk("scurve_dec", sd, scd);
  endtask
  // times in range: ramps 0..36000, s-curves 1..25 tenths
  task rset(input int lo, hi);
    for (int i = lo; i <= hi; i++) begin
      t[i] = i % 4 < 2 ? 16'(rnd() % 36001) : 16'(1 + rnd() % 25);
      host_u.wr(8'(4 * i), {16'h0, t[i]});
    end
  endtask
  // pins pass a two-flop synchroniser, so wait well past it
  task pins(input logic f, m, a, r);
    @(posedge mclk_i);
    {fsel, msel, asel, run} <= {f, m, a, r};
    repeat (4) @(posedge mclk_i);
  endtask
  task raise(input logic v);
    @(posedge mclk_i);
    fail <= v;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    #1 ramp(16'h0032, 16'h0032, 16'h0001, 16'h0001);
    host_u.rd(8'h14, rv);
    chk("fork_dec_rst", 32'hffff, rv);
    host_u.rd(8'h7c, rv);
    chk("unmapped", 32'h0, rv);
    repeat (3) begin
      rset(0, 3);
      host_u.seg();
      ramp(t[0], t[1], t[2], t[3]);
    end
    host_u.rd(8'h0c, rv);
    chk("readback", {16'h0, t[3]}, rv);
    $display("done primary");
    pins(0, 0, 1, 0);
    rset(8, 11);
    ramp(t[0], t[1], t[2], t[3]);
    host_u.seg();
    ramp(t[8], t[9], t[10], t[11]);
    host_u.wr(8'h24, 32'hffff);
    host_u.seg();
    ramp(t[8], t[8], t[10], t[11]);
    pins(0, 0, 0, 1);
    host_u.seg();
    ramp(t[8], t[8], t[10], t[11]);
    pins(0, 0, 0, 0);
    host_u.seg();
    ramp(t[0], t[1], t[2], t[3]);
    pins(0, 0, 1, 0);
    host_u.wr(8'h20, 32'hffff);
    host_u.seg();
    ramp(t[0], t[1], t[2], t[3]);
    $display("done third");
    pins(0, 1, 0, 0);
    rset(12, 15);
    host_u.seg();
    chk("speed_unmapped", 1'b0, sfeed);
    ramp(t[0], t[1], t[2], t[3]);
    host_u.wr(8'h50, 32'h6d00);
    host_u.seg();
    chk("speed", 1'b1, sfeed);
    ramp(t[12], t[13], t[14], t[15]);
    host_u.wr(8'h34, 32'hffff);
    host_u.seg();
    ramp(t[12], t[12], t[14], t[15]);
    host_u.wr(8'h30, 32'hffff);
    host_u.seg();
    chk("speed_dis", 1'b1, sfeed);
    ramp(t[0], t[1], t[2], t[3]);
    $display("done speed feed");
    pins(1, 0, 0, 0);
    host_u.wr(8'h4c, 32'h2);
    host_u.wr(8'h50, 32'h6d6c);
    rset(4, 7);
    host_u.seg();
    chk("fork_no_motor", 1'b0, fmode);
    chk("comm_stop", 16'h2, cst);
    host_u.wr(8'h48, 32'h1);
    host_u.seg();
    chk("fork", 1'b1, fmode);
    chk("comm_stop_fork", 16'h0, cst);
    ramp(t[4], t[5], t[6], t[7]);
    host_u.wr(8'h14, 32'hffff);
    host_u.seg();
    ramp(t[4], t[4], t[6], t[7]);
    raise(1'b1);
    ramp(t[4], t[4], t[6], t[7]);
    raise(1'b0);
    host_u.wr(8'h40, 32'h0100);
    host_u.wr(8'h44, 32'h0005);
    raise(1'b1);
    ramp(t[4], 16'h0100, t[6], 16'h0005);
    host_u.seg();
    ramp(t[4], 16'h0100, t[6], 16'h0005);
    host_u.rd(8'h54, rv);
    chk("status", 32'h11, rv);
    $display("done fork and failure");
    conclude();
  end
endmodule
